// ==== design/panel_strobe_port.v ====
// Purpose: strobe timing generator for a parallel command/data panel port
// Assumes: clk is the interconnect clock; APB register access; one access at a time
// Notes:   all edges from one counter restarted at the start of each access
`include "panel_strobe_regs.vh"

module panel_strobe_port #(
    parameter DATA_W = 16
) (
    input  wire              clk,
    input  wire              rst,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [5:0]        paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output wire              pslverr,
    output reg               chip_select_n,
    output reg               write_strobe_n,
    output reg               read_strobe_n,
    output reg               cmd_data_select,
    output reg  [DATA_W-1:0] data_out,
    output reg               data_out_en_n,
    input  wire [DATA_W-1:0] data_in
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACC  = 2'h1;
    localparam [1:0] ST_GAP  = 2'h2;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [31:0]       strobe_edge_times;
    reg [31:0]       access_cycle_times;
    reg [31:0]       strobe_edge_times_alt;
    reg [31:0]       access_cycle_times_alt;
    reg [31:0]       port_configuration_alt;
    reg [DATA_W-1:0] write_word;
    reg [DATA_W-1:0] read_word;
    reg [1:0]        state;
    reg [7:0]        count;
    reg              acc_read;
    reg              last_read;
    reg              had_access;
    reg              pend;
    reg              pend_read;
    reg              pend_cmd;

    wire wr_en = psel & penable & pwrite;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // decode of a known word offset; writes elsewhere are dropped so no alias lands
    function mapped;
        input [5:0] a;
        begin
            mapped = (a <= `OFS_STATUS) && (a[1:0] == 2'h0);
        end
    endfunction

    // ----------------------------------------------------------------
    // timing set selection and doubled counts
    // ----------------------------------------------------------------
    wire        use_alt = port_configuration_alt[`SET_SELECT_BIT];
    wire [31:0] edge_r  = use_alt ? strobe_edge_times_alt : strobe_edge_times;
    wire [31:0] cyc_r   = use_alt ? access_cycle_times_alt : access_cycle_times;
    wire        dbl     = port_configuration_alt[`DOUBLING_BIT];

    // scale a field to clock cycles; doubling is a shift so no multiplier
    function [7:0] scale;
        input [5:0] v;
        input       d;
        begin
            scale = d ? {1'b0, v, 1'b0} : {2'h0, v};
        end
    endfunction

    wire [7:0] cs_on   = scale({2'h0, edge_r[`CS_ON_HI:`CS_ON_LO]}, dbl);
    wire [7:0] cs_off  = scale(edge_r[`CS_OFF_HI:`CS_OFF_LO], dbl);
    wire [7:0] wr_on   = scale({2'h0, edge_r[`WR_ON_HI:`WR_ON_LO]}, dbl);
    wire [7:0] wr_off  = scale(edge_r[`WR_OFF_HI:`WR_OFF_LO], dbl);
    wire [7:0] rd_on   = scale({2'h0, edge_r[`RD_ON_HI:`RD_ON_LO]}, dbl);
    wire [7:0] rd_off  = scale(edge_r[`RD_OFF_HI:`RD_OFF_LO], dbl);
    wire [7:0] wcyc    = scale(cyc_r[`WCYC_HI:`WCYC_LO], dbl);
    wire [7:0] rcyc    = scale(cyc_r[`RCYC_HI:`RCYC_LO], dbl);
    wire [7:0] gapw    = scale(cyc_r[`GAPW_HI:`GAPW_LO], dbl);
    wire [7:0] capt    = scale(cyc_r[`CAPT_HI:`CAPT_LO], dbl);
    wire [7:0] cyc_end = acc_read ? rcyc : wcyc;

    // gap needed between the last access and the one pending
    wire gap_need = had_access & (gapw != 8'h00) &
                    ( last_read &  pend_read & cyc_r[`GAP_RR_BIT] |
                      last_read & ~pend_read & cyc_r[`GAP_RW_BIT] |
                     ~last_read & ~pend_read & cyc_r[`GAP_WW_BIT] |
                     ~last_read &  pend_read & cyc_r[`GAP_WR_BIT]);

    // ----------------------------------------------------------------
    // register writes; a start is held pending only while no other start is pending
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            strobe_edge_times      <= `EDGE_RESET;
            access_cycle_times     <= `CYCLE_RESET;
            strobe_edge_times_alt  <= `EDGE_ALT_RESET;
            access_cycle_times_alt <= `CYCLE_ALT_RESET;
            port_configuration_alt <= `CONFIG_RESET;
            write_word             <= {DATA_W{1'b0}};
        end else if (wr_en && mapped(paddr)) begin
            case (paddr)
                `OFS_EDGE:       strobe_edge_times      <= pwdata;
                `OFS_CYCLE:      access_cycle_times     <= pwdata;
                `OFS_EDGE_ALT:   strobe_edge_times_alt  <= pwdata;
                `OFS_CYCLE_ALT:  access_cycle_times_alt <= pwdata;
                `OFS_CONFIG_ALT: port_configuration_alt <= pwdata;
                `OFS_WDATA:      write_word             <= pwdata[DATA_W-1:0];
                default:         write_word             <= write_word;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // access sequencer: one counter drives every edge
    // ----------------------------------------------------------------
    wire start_req = wr_en & (paddr == `OFS_CONTROL) & pwdata[`CTRL_START_BIT];

    always @(posedge clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            count      <= 8'h00;
            acc_read   <= 1'b0;
            last_read  <= 1'b0;
            had_access <= 1'b0;
            pend       <= 1'b0;
            pend_read  <= 1'b0;
            pend_cmd   <= 1'b0;
            cmd_data_select <= 1'b1;
            read_word  <= {DATA_W{1'b0}};
        end else begin
            // a start request is taken only when none is pending, otherwise it is dropped
            if (start_req && !pend) begin
                pend      <= 1'b1;
                pend_read <= pwdata[`CTRL_READ_BIT];
                pend_cmd  <= pwdata[`CTRL_CMD_BIT];
            end
            case (state)
                ST_IDLE: begin
                    if (pend) begin
                        count <= 8'h00;
                        if (gap_need) begin
                            state <= ST_GAP;
                        end else begin
                            state    <= ST_ACC;
                            pend     <= 1'b0;
                            acc_read <= pend_read;
                            cmd_data_select <= ~pend_cmd;
                        end
                    end
                end
                ST_GAP: begin
                    // select line stays from the last access through the gap
                    if (count + 8'h01 >= gapw) begin
                        state    <= ST_ACC;
                        count    <= 8'h00;
                        pend     <= 1'b0;
                        acc_read <= pend_read;
                        cmd_data_select <= ~pend_cmd;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                ST_ACC: begin
                    if (acc_read && count == capt) begin
                        read_word <= data_in;
                    end
                    if (count + 8'h01 >= cyc_end) begin
                        state      <= ST_IDLE;
                        count      <= 8'h00;
                        last_read  <= acc_read;
                        had_access <= 1'b1;
                    end else begin
                        count <= count + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin outputs registered from the counter compares
    // ----------------------------------------------------------------
    wire in_acc = (state == ST_ACC);
    wire [7:0] next_count = (in_acc && count + 8'h01 < cyc_end) ? count + 8'h01 : 8'h00;
    wire       next_acc   = in_acc ? (count + 8'h01 < cyc_end) :
                            (state == ST_IDLE && pend && !gap_need) ||
                            (state == ST_GAP && count + 8'h01 >= gapw);
    wire       next_read  = in_acc ? acc_read : pend_read;

    // compares look one cycle ahead so pins change on the counted edge
    always @(posedge clk) begin
        if (rst) begin
            chip_select_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            read_strobe_n  <= 1'b1;
            data_out       <= {DATA_W{1'b0}};
            data_out_en_n  <= 1'b1;
        end else begin
            chip_select_n  <= ~(next_acc && next_count >= cs_on && next_count < cs_off);
            write_strobe_n <= ~(next_acc && !next_read && next_count >= wr_on && next_count < wr_off);
            read_strobe_n  <= ~(next_acc && next_read && next_count >= rd_on && next_count < rd_off);
            data_out_en_n  <= ~(next_acc && !next_read);
            if (next_acc && !next_read) begin
                data_out <= write_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB read data
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_EDGE:       prdata <= strobe_edge_times;
                `OFS_CYCLE:      prdata <= access_cycle_times;
                `OFS_EDGE_ALT:   prdata <= strobe_edge_times_alt;
                `OFS_CYCLE_ALT:  prdata <= access_cycle_times_alt;
                `OFS_CONFIG_ALT: prdata <= port_configuration_alt;
                `OFS_WDATA:      prdata <= {{(32-DATA_W){1'b0}}, write_word};
                `OFS_RDATA:      prdata <= {{(32-DATA_W){1'b0}}, read_word};
                `OFS_STATUS:     prdata <= {31'h0, (state != ST_IDLE) | pend};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ==== design/panel_strobe_regs.vh ====
// Purpose: register map, field positions and reset values of the panel strobe port
// Assumes: APB slave with 32-bit words, byte addresses below
// Notes:   reset values give the LCD panel timing at a 200 MHz interconnect clock
`ifndef PANEL_STROBE_REGS_VH
`define PANEL_STROBE_REGS_VH

// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define OFS_EDGE        6'h00
`define OFS_CYCLE       6'h04
`define OFS_EDGE_ALT    6'h08
`define OFS_CYCLE_ALT   6'h0C
`define OFS_CONFIG_ALT  6'h10
`define OFS_CONTROL     6'h14
`define OFS_WDATA       6'h18
`define OFS_RDATA       6'h1C
`define OFS_STATUS      6'h20

// ----------------------------------------------------------------
// edge register fields
// ----------------------------------------------------------------
`define CS_ON_HI        3
`define CS_ON_LO        0
`define CS_OFF_HI       9
`define CS_OFF_LO       4
`define WR_ON_HI        13
`define WR_ON_LO        10
`define WR_OFF_HI       19
`define WR_OFF_LO       14
`define RD_ON_HI        23
`define RD_ON_LO        20
`define RD_OFF_HI       29
`define RD_OFF_LO       24

// ----------------------------------------------------------------
// cycle register fields
// ----------------------------------------------------------------
`define WCYC_HI         5
`define WCYC_LO         0
`define RCYC_HI         11
`define RCYC_LO         6
`define GAPW_HI         17
`define GAPW_LO         12
`define GAP_RW_BIT      18
`define GAP_RR_BIT      19
`define GAP_WW_BIT      20
`define GAP_WR_BIT      21
`define CAPT_HI         27
`define CAPT_LO         22

// ----------------------------------------------------------------
// configuration, control and status bits
// ----------------------------------------------------------------
`define DOUBLING_BIT    4
`define SET_SELECT_BIT  1
`define CTRL_START_BIT  0
`define CTRL_READ_BIT   1
`define CTRL_CMD_BIT    2
`define STAT_BUSY_BIT   0

// ----------------------------------------------------------------
// reset values (set 0: LCD panel, set 1: projector driver)
// ----------------------------------------------------------------
`define EDGE_RESET      32'h0D61_88D0
`define CYCLE_RESET     32'h0000_034A
`define EDGE_ALT_RESET  32'h0001_0080
`define CYCLE_ALT_RESET 32'h0000_0008
`define CONFIG_RESET    32'h0000_0000

`endif

// ==== tb/panel_strobe_check_sva.sv ====
// Purpose: port-level checks of the panel strobe port
// Assumes: bound to every panel_strobe_port instance
// Notes:   sees ports only, so timing figures are checked by the bench
`include "panel_strobe_regs.vh"
module panel_strobe_check #(
    parameter DATA_W = 16
) (
    input wire              clk,
    input wire              rst,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [5:0]        paddr,
    input wire [31:0]       pwdata,
    input wire              pready,
    input wire [31:0]       prdata,
    input wire              pslverr,
    input wire              chip_select_n,
    input wire              write_strobe_n,
    input wire              read_strobe_n,
    input wire              cmd_data_select,
    input wire [DATA_W-1:0] data_out,
    input wire              data_out_en_n,
    input wire [DATA_W-1:0] data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ready; pready && !pslverr; endproperty
    property p_excl; write_strobe_n || read_strobe_n; endproperty
    property p_wr_drive; !write_strobe_n |-> !data_out_en_n; endproperty
    property p_rd_float; !read_strobe_n |-> data_out_en_n; endproperty
    property p_wdata; !write_strobe_n && !$past(write_strobe_n) |-> $stable(data_out); endproperty
    property p_sel;
        (!write_strobe_n && !$past(write_strobe_n)) || (!read_strobe_n && !$past(read_strobe_n))
        |-> $stable(cmd_data_select);
    endproperty
    property p_unmapped; psel && penable && !pwrite && paddr > `OFS_STATUS |-> prdata == 32'h0; endproperty
    // reset is checked with its own disable, the default one would hide it
    property p_reset;
        disable iff (1'b0) rst |=> chip_select_n && write_strobe_n && read_strobe_n && data_out_en_n;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer not ready or error");
    a_excl: assert property (p_excl) else $error("both strobes low");
    a_wr_drive: assert property (p_wr_drive) else $error("write strobe low with bus released");
    a_rd_float: assert property (p_rd_float) else $error("read strobe low with bus driven");
    a_wdata: assert property (p_wdata) else $error("write data moved under strobe");
    a_sel: assert property (p_sel) else $error("select moved under strobe");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_reset: assert property (p_reset) else $error("pins not idle after reset");
    c_wr: cover property ($fell(write_strobe_n));
    c_rd: cover property ($fell(read_strobe_n));
    c_unmapped: cover property (psel && penable && !pwrite && paddr > `OFS_STATUS);
endmodule

bind panel_strobe_port panel_strobe_check #(.DATA_W(DATA_W)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .cmd_data_select(cmd_data_select),
    .data_out(data_out), .data_out_en_n(data_out_en_n), .data_in(data_in));

// ==== tb/panel_model.sv ====
// Purpose: panel controller with its own frame store
// Assumes: read data only valid while the read strobe is low
// Notes:   released bus toggles every cycle so stale data never matches
module panel_model #(
    parameter DATA_W = 16
) (
    input  wire               clk,
    input  wire               write_strobe_n,
    input  wire               read_strobe_n,
    input  wire               cmd_data_select,
    input  wire  [DATA_W-1:0] data_out,
    input  wire  [DATA_W-1:0] reply_word,
    output logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] store_word,
    output logic              store_cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic              we_q = 1'b1;
    logic [DATA_W-1:0] junk = {(DATA_W/2){2'b10}};
    // word only while strobe is low, otherwise a changing pattern
    assign data_in = read_strobe_n ? junk : reply_word;
    // frame store takes the word at the rising write strobe
    always @(posedge clk) begin
        junk <= ~junk;
        we_q <= write_strobe_n;
        if (write_strobe_n && !we_q) begin
            store_word <= data_out;
            store_cmd  <= cmd_data_select;
        end
    end
endmodule

// ==== tb/panel_strobe_port_bench.sv ====
// Purpose: self-checking bench of the panel strobe port
// Assumes: clk stands for the interconnect clock
// Notes:   every pin, data_out on writes only, is compared on each cycle of every access against the programmed counts
`include "panel_strobe_regs.vh"
module panel_strobe_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] reply_word = 16'h0;
    logic [31:0] q;
    wire         pready, pslverr, chip_select_n, write_strobe_n, read_strobe_n, cmd_data_select;
    wire         data_out_en_n, store_cmd;
    wire  [31:0] prdata;
    wire  [15:0] data_out, data_in, store_word;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cs_on, cs_off, wr_on, wr_off, rd_on, rd_off, wcyc, rcyc, capt, dbl, alt;
    int          gap_w, gap_en, last_rd = -1;

    initial forever #5 clk = ~clk;

    panel_strobe_port #(.DATA_W(16)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .cmd_data_select(cmd_data_select),
        .data_out(data_out), .data_out_en_n(data_out_en_n), .data_in(data_in));
    panel_model #(.DATA_W(16)) u_panel (
        .clk(clk), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .cmd_data_select(cmd_data_select), .data_out(data_out), .reply_word(reply_word),
        .data_in(data_in), .store_word(store_word), .store_cmd(store_cmd));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; waits an edge first so no signal is assigned twice
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] edge_word();
        return cs_on | cs_off << 4 | wr_on << 10 | wr_off << 14 | rd_on << 20 | rd_off << 24;
    endfunction
    function automatic logic [31:0] cycle_word();
        return wcyc | rcyc << 6 | gap_w << 12 | gap_en << 18 | capt << 22;
    endfunction
    function automatic logic low(int on, int off, int k);
        return k >= on * (dbl + 1) && k < off * (dbl + 1);
    endfunction
    // projector preset when p is set, panel preset otherwise
    task automatic preset(input logic p);
        {cs_on, wr_on, rd_on, capt, dbl, alt, gap_w, gap_en} = {8{32'sd0}};
        {cs_off, wr_off, rd_off, wcyc, rcyc} = p ? {32'sd8, 32'sd4, 32'sd0, 32'sd8, 32'sd0}
                                                 : {32'sd13, 32'sd6, 32'sd13, 32'sd10, 32'sd13};
        wr_on = p ? 0 : 2;
        rd_on = p ? 0 : 6;
        alt = p;
    endtask
    task automatic program_set;
        apb(1'b1, alt ? `OFS_EDGE_ALT : `OFS_EDGE, edge_word());
        apb(1'b1, alt ? `OFS_CYCLE_ALT : `OFS_CYCLE, cycle_word());
        apb(1'b1, `OFS_CONFIG_ALT, dbl << `DOUBLING_BIT | alt << `SET_SELECT_BIT);
        apb(1'b0, alt ? `OFS_EDGE_ALT : `OFS_EDGE, 32'h0);
        chk("edge readback", edge_word(), q);
    endtask
    // one panel access, every pin (data_out on writes only) compared on every count of the access
    task automatic access(input logic rd, input logic cmd, input logic [15:0] w);
        int n;
        int g;
        int pair;
        logic s;
        s = cmd_data_select;
        // enable bit of the pair: read-write 0, read-read 1, write-write 2, write-read 3
        pair = last_rd ? (rd ? 1 : 0) : (rd ? 3 : 2);
        g = (last_rd < 0 || gap_w == 0) ? 0 : ((gap_en >> pair) & 1) * gap_w * (dbl + 1);
        last_rd = rd;
        reply_word <= w;
        if (!rd) apb(1'b1, `OFS_WDATA, {16'h0, w});
        apb(1'b1, `OFS_CONTROL, {29'h0, cmd, rd, 1'b1});
        repeat (g) begin
            @(posedge clk);
            #1;
            chk("gap chip select", 1, chip_select_n);
            chk("gap select", s, cmd_data_select);
        end
        n = (rd ? rcyc : wcyc) * (dbl + 1);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            #1;
            chk("chip select", !low(cs_on, cs_off, k), chip_select_n);
            chk("write strobe", rd | !low(wr_on, wr_off, k), write_strobe_n);
            chk("read strobe", !rd | !low(rd_on, rd_off, k), read_strobe_n);
            chk("select", !cmd, cmd_data_select);
            chk("bus drive", rd, data_out_en_n);
            if (!rd) chk("data out", w, data_out);
        end
        n = 0;
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end while (q[`STAT_BUSY_BIT] !== 1'b0 && n < 20);
        chk("busy", 0, q[`STAT_BUSY_BIT]);
        if (rd) begin
            apb(1'b0, `OFS_RDATA, 32'h0);
            chk("read word", {16'h0, w}, q);
        end else begin
            chk("stored word", w, store_word);
            chk("stored kind", !cmd, store_cmd);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h908E4886));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        preset(1'b0);
        apb(1'b0, `OFS_EDGE, 32'h0);
        chk("panel edge reset", edge_word(), q);
        apb(1'b0, `OFS_CYCLE, 32'h0);
        chk("panel cycle reset", cycle_word(), q);
        preset(1'b1);
        apb(1'b0, `OFS_EDGE_ALT, 32'h0);
        chk("projector edge reset", edge_word(), q);
        apb(1'b0, `OFS_CYCLE_ALT, 32'h0);
        chk("projector cycle reset", cycle_word(), q);
        apb(1'b0, `OFS_CONFIG_ALT, 32'h0);
        chk("config reset", 0, q);
        apb(1'b0, 6'h24, 32'h0);
        chk("unmapped read", 0, q);
        apb(1'b1, `OFS_CONFIG_ALT, 1 << `SET_SELECT_BIT);
        access(1'b0, 1'b0, 16'hA55A);
        preset(1'b0);
        apb(1'b1, `OFS_CONFIG_ALT, 32'h0);
        access(1'b0, 1'b1, 16'h00FF);
        capt = 10;
        program_set();
        access(1'b1, 1'b0, 16'h5AC3);
        // random counts keep capture inside the read strobe whatever the doubling
        repeat (14) begin
            dbl = $urandom % 2;
            alt = $urandom % 2;
            cs_on = $urandom % 4;
            cs_off = cs_on + 1 + $urandom % 14;
            wr_on = $urandom % 4;
            wr_off = wr_on + 1 + $urandom % 6;
            rd_on = $urandom % 4;
            capt = 2 * rd_on + 2 + $urandom % 2;
            rd_off = capt + 2 + $urandom % 3;
            wcyc = wr_off + $urandom % 3;
            rcyc = rd_off + $urandom % 3;
            gap_w = $urandom % 4;
            gap_en = $urandom % 16;
            program_set();
            access($urandom % 2, $urandom % 2, $urandom);
        end
        tally_and_finish();
    end
endmodule
